// File: rtl/lmr_decode.sv
// Purpose: decode and execute literal load, store, no-op, config load
//          and return-with-literal
// Assumes: instr_valid_i marks one instruction cycle per pulse
// Notes: status flags are never touched by this group
//
// Behaviour
// [RQ1] config-load copies work register, status unchanged
// [RQ2] return-with-literal loads literal into work register
// [RQ3] return-with-literal reloads pc from stack top
// [RQ4] return-with-literal takes two instruction cycles
// [RQ5] literal load, store, no-op: single cycle
`timescale 1ns/1ps
`include "lmr_defines.svh"

module lmr_decode #(
    parameter int PC_W = 9
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [11:0] instr_i,
    input wire logic [PC_W-1:0] stack_top_entry_i,
    output logic [7:0] work_o,
    output logic [7:0] cfg_o,
    output lmr_pkg::lmr_file_wr_t file_wr_o,
    output lmr_pkg::lmr_pc_load_t pc_load_o,
    output logic stack_pop_o,
    output logic flush_o,
    output logic busy_o,
    output logic done_o,
    output logic status_we_o
);

    lmr_pkg::lmr_state_reg_t st_ff;
    lmr_pkg::lmr_state_reg_t nxt_st;
    lmr_pkg::lmr_op_t op;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic lmr_pkg::lmr_op_t decode_op(input logic [11:0] w);
        if (w == `LMR_ENC_NOP) begin
            return lmr_pkg::LMR_OP_NOP;
        end else if (w == `LMR_ENC_CFG) begin
            return lmr_pkg::LMR_OP_CFG;
        end else if (w[11:5] == `LMR_STORE_HI) begin
            return lmr_pkg::LMR_OP_STORE;
        end else if (w[11:8] == `LMR_TOP_LIT_W) begin
            return lmr_pkg::LMR_OP_LIT_W;
        end else if (w[11:8] == `LMR_TOP_RET_LIT) begin
            return lmr_pkg::LMR_OP_RET;
        end
        return lmr_pkg::LMR_OP_OTHER;
    endfunction

    // ------------------------------------------------------------
    // field helpers
    // ------------------------------------------------------------
    // literal field shared by literal load and return-with-literal
    function automatic logic [7:0] lit_of(input logic [11:0] w);
        return w[7:0];
    endfunction

    // file write request built from the word and the work register
    function automatic lmr_pkg::lmr_file_wr_t file_wr_of(
        input logic [11:0] w,
        input logic [7:0] data
    );
        lmr_pkg::lmr_file_wr_t f;
        f.valid = 1'b1;
        f.addr = w[4:0];
        f.data = data;
        return f;
    endfunction

    // pc reload request from the stack top, cut to the pc field width
    function automatic lmr_pkg::lmr_pc_load_t pc_load_of(
        input logic [PC_W-1:0] top
    );
        lmr_pkg::lmr_pc_load_t p;
        p.load = 1'b1;
        p.addr = 9'(top);
        return p;
    endfunction

    assign op = decode_op(instr_i);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.file_wr.valid = 1'b0;
        nxt_st.pc_load.load = 1'b0;
        nxt_st.pop = 1'b0;
        nxt_st.done = 1'b0;
        unique case (st_ff.state)
            lmr_pkg::LMR_ST_EXEC: begin
                if (instr_valid_i) begin
                    unique case (op)
                        lmr_pkg::LMR_OP_NOP: begin
                            nxt_st.done = 1'b1; // [RQ5]
                        end
                        lmr_pkg::LMR_OP_LIT_W: begin
                            nxt_st.work = lit_of(instr_i); // [RQ5]
                            nxt_st.done = 1'b1;
                        end
                        lmr_pkg::LMR_OP_STORE: begin
                            // [RQ5]
                            nxt_st.file_wr = file_wr_of(instr_i, st_ff.work);
                            nxt_st.done = 1'b1;
                        end
                        lmr_pkg::LMR_OP_CFG: begin
                            nxt_st.cfg = st_ff.work; // [RQ1]
                            nxt_st.done = 1'b1;
                        end
                        lmr_pkg::LMR_OP_RET: begin
                            nxt_st.work = lit_of(instr_i); // [RQ2]
                            // [RQ3]
                            nxt_st.pc_load = pc_load_of(stack_top_entry_i);
                            nxt_st.pop = 1'b1;
                            nxt_st.state = lmr_pkg::LMR_ST_FLUSH; // [RQ4]
                        end
                        lmr_pkg::LMR_OP_OTHER: begin
                        end
                    endcase
                end
            end
            lmr_pkg::LMR_ST_FLUSH: begin
                // second cycle: fetched word is discarded
                if (instr_valid_i) begin
                    nxt_st.state = lmr_pkg::LMR_ST_EXEC; // [RQ4]
                    nxt_st.done = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_ff.state <= lmr_pkg::LMR_ST_EXEC;
            st_ff.work <= `LMR_RESET_WORK;
            st_ff.cfg <= `LMR_RESET_CFG;
            st_ff.file_wr <= '0;
            st_ff.pc_load <= '0;
            st_ff.pop <= 1'b0;
            st_ff.done <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign work_o = st_ff.work;
    assign cfg_o = st_ff.cfg;
    assign file_wr_o = st_ff.file_wr;
    assign pc_load_o = st_ff.pc_load;
    assign stack_pop_o = st_ff.pop;
    assign flush_o = (st_ff.state == lmr_pkg::LMR_ST_FLUSH);
    assign busy_o = flush_o;
    assign done_o = st_ff.done;
    // none of these instructions write status
    assign status_we_o = 1'b0; // [RQ1] [RQ3] [RQ5]

endmodule

// File: shared/lmr_defines.svh
// Purpose: constants for the literal/move/return decoder
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: definitions only
`ifndef LMR_DEFINES_SVH
`define LMR_DEFINES_SVH

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define LMR_ENC_NOP 12'h000
`define LMR_ENC_CFG 12'h002
`define LMR_TOP_LIT_W 4'hC
`define LMR_TOP_RET_LIT 4'h8
`define LMR_STORE_HI 7'h01
`define LMR_RESET_WORK 8'h00
`define LMR_RESET_CFG 8'hFF

`endif

// File: shared/lmr_pkg.sv
// Purpose: types for the literal/move/return decoder
// Assumes: nothing
// Notes: none
package lmr_pkg;
    typedef enum logic [2:0] {
        LMR_OP_NOP,
        LMR_OP_LIT_W,
        LMR_OP_STORE,
        LMR_OP_CFG,
        LMR_OP_RET,
        LMR_OP_OTHER
    } lmr_op_t;

    typedef enum logic {
        LMR_ST_EXEC,
        LMR_ST_FLUSH
    } lmr_state_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [7:0] data;
    } lmr_file_wr_t;

    typedef struct packed {
        logic load;
        logic [8:0] addr;
    } lmr_pc_load_t;

    typedef struct packed {
        lmr_state_t state;
        logic [7:0] work;
        logic [7:0] cfg;
        lmr_file_wr_t file_wr;
        lmr_pc_load_t pc_load;
        logic pop;
        logic done;
    } lmr_state_reg_t;
endpackage

// File: sim/lmr_stack_model.sv
// Purpose: return stack seen by the decoder
// Assumes: push and pop never share a cycle
// Notes: a popped entry reads back inverted
`timescale 1ns/1ps
module lmr_stack_model (
    input wire logic clk_sys_i,
    input wire logic push_i,
    input wire logic [8:0] addr_i,
    input wire logic pop_i,
    output logic [8:0] top_o
);
    always_ff @(posedge clk_sys_i) begin
        if (push_i) top_o <= addr_i;
        else if (pop_i) top_o <= ~top_o;
    end
endmodule

// File: sim/lmr_decode_properties.sv
// Purpose: port checks for the decoder
// Assumes: one clock domain
// Notes: bound to lmr_decode
`timescale 1ns/1ps
module lmr_decode_properties #(parameter int PC_W = 9) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [11:0] instr_i,
    input wire logic [PC_W-1:0] stack_top_entry_i,
    input wire logic [7:0] work_o,
    input wire logic [7:0] cfg_o,
    input wire lmr_pkg::lmr_file_wr_t file_wr_o,
    input wire lmr_pkg::lmr_pc_load_t pc_load_o,
    input wire logic stack_pop_o,
    input wire logic flush_o,
    input wire logic done_o
);
    wire take = instr_valid_i && !flush_o;
    wire ret = take && instr_i[11:8] == 4'h8;
    wire lit = take && instr_i[11:8] == 4'hc;
    wire st = take && instr_i[11:5] == 7'h01;
    wire no_operation = take && instr_i == 12'h000;
    wire cfg = take && instr_i == 12'h002;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    property p_cfg; cfg |=> cfg_o == $past(work_o); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg load");
    property p_rw; ret |=> work_o == $past(instr_i[7:0]) && flush_o;
    endproperty
    a_rw: assert property (p_rw) else $error("return work");
    property p_pc; ret |=> stack_pop_o &&
        pc_load_o == {1'b1, $past(stack_top_entry_i)}; endproperty
    a_pc: assert property (p_pc) else $error("return pc");
    property p_fl; flush_o && instr_valid_i |=> !flush_o && done_o;
    endproperty
    a_fl: assert property (p_fl) else $error("flush end");
    property p_nd; ret |=> !done_o; endproperty
    a_nd: assert property (p_nd) else $error("early done");
    property p_lit; lit |=> work_o == $past(instr_i[7:0]); endproperty
    a_lit: assert property (p_lit) else $error("literal");
    property p_st; st |=> file_wr_o ==
        {1'b1, $past(instr_i[4:0]), $past(work_o)}; endproperty
    a_st: assert property (p_st) else $error("store");
    property p_nop; no_operation |=> $stable(work_o) && $stable(cfg_o) && done_o;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op");
endmodule
bind lmr_decode lmr_decode_properties #(.PC_W(PC_W)) u_chk (.*);

// File: sim/tb.sv
// Purpose: random and corner runs of the decoder
// Assumes: one instruction at a time
// Notes: a return step adds its discarded cycle
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 0, reset_i = 1, instr_valid_i = 0, push = 0;
    logic [11:0] instr_i = '0;
    logic [8:0] top, ret;
    logic [7:0] w = 8'h00, c = 8'hff, w0, work_o, cfg_o;
    logic [31:0] rnd = 32'hb0fb_fbce;
    int error_cnt = 0, n_tests = 0;
    lmr_pkg::lmr_file_wr_t file_wr_o;
    lmr_pkg::lmr_pc_load_t pc_load_o;
    logic stack_pop_o, flush_o, done_o, busy_o, status_we_o;
    lmr_decode dut (.clk_sys_i, .reset_i, .instr_valid_i, .instr_i,
        .stack_top_entry_i(top), .work_o, .cfg_o, .file_wr_o, .pc_load_o,
        .stack_pop_o, .flush_o, .busy_o, .done_o, .status_we_o);
    lmr_stack_model stk (.clk_sys_i, .push_i(push), .addr_i(ret),
        .pop_i(stack_pop_o), .top_o(top));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string n, input logic [17:0] e, g);
        n_tests++;
        if (e !== g) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input logic [11:0] ins);
        @(negedge clk_sys_i);
        push = 0;
        instr_valid_i = 1;
        instr_i = ins;
        @(negedge clk_sys_i);
        instr_valid_i = 0;
    endtask
    task automatic step(input logic [11:0] ins);
        logic r, g;
        r = ins[11:8] == 4'h8;
        g = ins == 0 || ins == 2 || ins[11:8] == 4'hc || ins[11:5] == 1;
        rnd = xs(rnd);
        ret = rnd[8:0];
        w0 = w;
        @(negedge clk_sys_i);
        push = 1;
        cyc(ins);
        if (r || ins[11:8] == 4'hc) w = ins[7:0];
        if (ins == 12'h002) c = w0;
        chk("work", w, work_o);
        chk("cfg", c, cfg_o);
        chk("file_v", ins[11:5] == 7'h01, file_wr_o.valid);
        if (ins[11:5] == 7'h01) begin
            chk("file", {1'b1, ins[4:0], w0}, file_wr_o);
        end
        chk("status", 1'b0, status_we_o);
        chk("busy", r, busy_o);
        chk("done", g && !r, done_o);
        chk("pc", {r, r ? ret : pc_load_o.addr, r, r},
            {pc_load_o, stack_pop_o, flush_o});
        if (r) begin
            cyc({4'hc, ~ins[7:0]});
            chk("flush", {w, 2'b01}, {work_o, flush_o, done_o});
        end
    endtask
    initial begin
        repeat (16) @(negedge clk_sys_i);
        reset_i = 0;
        step(12'hc5a);
        step(12'h03f);
        step(12'h002);
        step(12'h8ff);
        step(12'h800);
        step(12'h000);
        step(12'h020);
        repeat (300) step(rnd[2] ? {rnd[3] ? 4'h8 : 4'hc, rnd[15:8]} :
            rnd[1] ? {7'h01, rnd[12:8]} : rnd[27:16]);
        @(negedge clk_sys_i);
        reset_i = 1;
        repeat (2) @(negedge clk_sys_i);
        w = 8'h00;
        c = 8'hff;
        chk("rst", {w, c, 2'b00}, {work_o, cfg_o, flush_o, done_o});
        reset_i = 0;
        step(12'hc3c);
        step(12'h002);
        step(12'h8a5);
        summarize();
    end
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
endmodule
